/* hw/dacbuf_host.sv */
// Host controller driving the double-buffered converter input latches
`timescale 1ns/10ps
// Function
// - Low register enable moves latch into converter
// - Low input enable loads parallel pins
// - Word pin 15 is MSB, 0 LSB
// - Unipolar: host inverts MSB before sending
// - Byte enables load bytes, third transfers
// - Both byte enables low selects serial
module dacbuf_host (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire dacbuf_pkg::dacbuf_req_t req_in,
	input wire logic clear_req_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [15:0] data_out,
	output dacbuf_pkg::dacbuf_ctl_t ctl_out
);
	import dacbuf_pkg::*;

	typedef struct packed {
		dacbuf_state_t state;
		logic [15:0] word;
		logic [1:0] mode;
		logic [1:0] phase;
		logic [4:0] bits_left;
		logic ready;
		logic done;
		logic [15:0] data;
		dacbuf_ctl_t ctl;
		logic load;
		logic [7:0] count;
	} dacbuf_host_t;

	localparam dacbuf_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	dacbuf_host_t st_reg, st_next;
	logic tmr_done;

	dacbuf_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.load_in(st_reg.load),
		.count_in(st_reg.count),
		.done_out(tmr_done)
	);

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.load = 1'b0;
		case (st_reg.state)
			DACBUF_IDLE: begin
				st_next.ctl = CTL_IDLE;
				st_next.ready = 1'b1;
				if (clear_req_in && st_reg.ready) begin
					st_next.ready = 1'b0;
					st_next.ctl.clear_n = 1'b0;
					st_next.load = 1'b1;
					st_next.count = DACBUF_STROBE_CNT;
					st_next.state = DACBUF_CLEAR;
				end else if (req_valid_in && st_reg.ready) begin
					st_next.ready = 1'b0;
					// Two's complement passes as is, unipolar flips MSB
					st_next.word = req_in.unipolar ? (req_in.word ^ DACBUF_MSB_FLIP) :
						req_in.word;
					st_next.mode = req_in.mode;
					st_next.phase = 2'h0;
					st_next.bits_left = 5'(DACBUF_SER_BITS);
					st_next.load = 1'b1;
					st_next.count = DACBUF_SETUP_CNT;
					st_next.state = DACBUF_SETUP;
				end
			end
			DACBUF_SETUP: begin
				st_next.ctl.write_n = 1'b1;
				case (st_reg.mode)
					DACBUF_MODE_BYTE: begin
						// Low byte first, then high byte on the same pins
						st_next.data = {8'h00, (st_reg.phase == 2'h0) ?
							st_reg.word[DACBUF_HIGH_LSB-1:0] :
							st_reg.word[DACBUF_MSB:DACBUF_HIGH_LSB]};
					end
					DACBUF_MODE_SERIAL: begin
						// MSB first on pin 0
						st_next.data = {15'h0000, st_reg.word[DACBUF_MSB]};
					end
					default: begin
						st_next.data = st_reg.word;
					end
				endcase
				if (tmr_done) begin
					st_next.ctl.write_n = 1'b0;
					st_next.ctl.select_n = (st_reg.mode == DACBUF_MODE_WORD);
					case (st_reg.mode)
						DACBUF_MODE_BYTE: begin
							st_next.ctl.low_byte_latch_n = (st_reg.phase != 2'h0);
							st_next.ctl.high_byte_latch_n = (st_reg.phase == 2'h0);
						end
						DACBUF_MODE_SERIAL: begin
							st_next.ctl.low_byte_latch_n = 1'b0;
							st_next.ctl.high_byte_latch_n = 1'b0;
						end
						default: begin
							st_next.ctl.input_latch_enable_n = 1'b0;
						end
					endcase
					st_next.load = 1'b1;
					st_next.count = DACBUF_STROBE_CNT;
					st_next.state = DACBUF_STROBE;
				end
			end
			DACBUF_STROBE: begin
				if (tmr_done) begin
					st_next.ctl = CTL_IDLE;
					st_next.load = 1'b1;
					st_next.count = DACBUF_SETUP_CNT;
					st_next.state = DACBUF_SETUP;
					if (st_reg.mode == DACBUF_MODE_SERIAL) begin
						st_next.ctl.select_n = 1'b0;
						st_next.ctl.low_byte_latch_n = 1'b0;
						st_next.ctl.high_byte_latch_n = 1'b0;
						st_next.word = {st_reg.word[DACBUF_MSB-1:0], 1'b0};
						st_next.bits_left = st_reg.bits_left - 5'h01;
						if (st_reg.bits_left == 5'h01) begin
							st_next.ctl = CTL_IDLE;
							st_next.state = DACBUF_GAP;
						end
					end else if (st_reg.mode == DACBUF_MODE_BYTE && st_reg.phase == 2'h0) begin
						st_next.phase = 2'h1;
					end else begin
						st_next.state = DACBUF_GAP;
					end
				end
			end
			DACBUF_GAP: begin
				if (tmr_done) begin
					st_next.ctl.write_n = 1'b0;
					if (st_reg.mode == DACBUF_MODE_WORD) begin
						st_next.ctl.dac_register_enable_n = 1'b0;
					end else begin
						st_next.ctl.select_n = 1'b0;
						st_next.ctl.dac_transfer_enable_n = 1'b0;
					end
					st_next.load = 1'b1;
					st_next.count = DACBUF_STROBE_CNT;
					st_next.state = DACBUF_XFER;
				end
			end
			DACBUF_XFER: begin
				if (tmr_done) begin
					st_next.ctl = CTL_IDLE;
					st_next.done = 1'b1;
					st_next.state = DACBUF_IDLE;
				end
			end
			DACBUF_CLEAR: begin
				if (tmr_done) begin
					st_next.ctl = CTL_IDLE;
					st_next.done = 1'b1;
					st_next.state = DACBUF_IDLE;
				end
			end
			default: begin
				st_next.ctl = CTL_IDLE;
				st_next.state = DACBUF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
			st_reg.ctl <= CTL_IDLE;
			st_reg.state <= DACBUF_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready_out = st_reg.ready;
	assign done_out = st_reg.done;
	assign data_out = st_reg.data;
	assign ctl_out = st_reg.ctl;
endmodule

/* hw/dacbuf_pkg.sv */
// Package for the converter input-latch host controller
package dacbuf_pkg;
	localparam int unsigned DACBUF_WORD_W = 16;
	localparam int unsigned DACBUF_BYTE_W = 8;
	localparam int unsigned DACBUF_MSB = 15;
	localparam int unsigned DACBUF_HIGH_LSB = 8;
	localparam int unsigned DACBUF_SER_BITS = 16;
	localparam int unsigned DACBUF_CLK_MHZ = 50;
	localparam int unsigned DACBUF_SETUP_NS = 100;
	localparam int unsigned DACBUF_STROBE_NS = 100;
	localparam int unsigned DACBUF_SETUP_CYC = (DACBUF_SETUP_NS * DACBUF_CLK_MHZ + 999) / 1000;
	localparam int unsigned DACBUF_STROBE_CYC = (DACBUF_STROBE_NS * DACBUF_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] DACBUF_SETUP_CNT = 8'(DACBUF_SETUP_CYC);
	localparam logic [7:0] DACBUF_STROBE_CNT = 8'(DACBUF_STROBE_CYC);
	localparam logic [15:0] DACBUF_ZERO_WORD = 16'h0000;
	localparam logic [15:0] DACBUF_MSB_FLIP = 16'h8000;
	localparam logic [1:0] DACBUF_MODE_WORD = 2'h0;
	localparam logic [1:0] DACBUF_MODE_BYTE = 2'h1;
	localparam logic [1:0] DACBUF_MODE_SERIAL = 2'h2;

	typedef enum logic [2:0] {
		DACBUF_IDLE = 3'h0,
		DACBUF_SETUP = 3'h1,
		DACBUF_STROBE = 3'h3,
		DACBUF_GAP = 3'h2,
		DACBUF_XFER = 3'h6,
		DACBUF_CLEAR = 3'h7
	} dacbuf_state_t;

	typedef struct packed {
		logic [15:0] word;
		logic [1:0] mode;
		logic unipolar;
	} dacbuf_req_t;

	typedef struct packed {
		logic write_n;
		logic select_n;
		logic input_latch_enable_n;
		logic dac_register_enable_n;
		logic low_byte_latch_n;
		logic high_byte_latch_n;
		logic dac_transfer_enable_n;
		logic clear_n;
	} dacbuf_ctl_t;
endpackage

/* hw/dacbuf_timer.sv */
// Cycle counter that pulses done after a loaded count
`timescale 1ns/10ps
module dacbuf_timer (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [7:0] count_in,
	output logic done_out
);
	typedef struct packed {
		logic [7:0] cnt;
		logic run;
		logic done;
	} dacbuf_tmr_t;
	dacbuf_tmr_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (load_in) begin
			st_next.cnt = count_in;
			st_next.run = 1'b1;
		end else if (st_reg.run) begin
			if (st_reg.cnt <= 8'h01) begin
				st_next.run = 1'b0;
				st_next.done = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - 8'h01;
			end
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign done_out = st_reg.done;
endmodule

/* verification/dacbuf_dev_model.sv */
// Behavioural model of the double-buffered converter inputs
`timescale 1ns/10ps
module dacbuf_dev_model (
	input wire logic [15:0] data_in,
	input wire dacbuf_pkg::dacbuf_ctl_t ctl_in,
	output logic [15:0] word_dac_out,
	output logic [15:0] byte_latch_out,
	output logic [15:0] byte_dac_out
);
	import dacbuf_pkg::*;
	logic [15:0] word_reg;
	logic wr, lo, hi, cs, ser_wr, ser_bit;
	always @(ctl_in, data_in) begin
		wr = !ctl_in.write_n;
		lo = !ctl_in.low_byte_latch_n;
		hi = !ctl_in.high_byte_latch_n;
		cs = !ctl_in.select_n;
		if (!ctl_in.clear_n) begin
			word_reg = 16'h0000;
			byte_latch_out = 16'h0000;
			word_dac_out = 16'h0000;
			byte_dac_out = 16'h0000;
		end else begin
			if (wr && !ctl_in.input_latch_enable_n) word_reg = data_in;
			if (wr && !ctl_in.dac_register_enable_n) word_dac_out = word_reg;
			if (wr && cs && lo && !hi) byte_latch_out[7:0] = data_in[7:0];
			if (wr && cs && hi && !lo) byte_latch_out[15:8] = data_in[7:0];
			if (!wr && ser_wr) byte_latch_out = {byte_latch_out[14:0], ser_bit};
			if (wr && cs && !ctl_in.dac_transfer_enable_n) byte_dac_out = byte_latch_out;
		end
		ser_wr = wr && cs && lo && hi;
		if (ser_wr) ser_bit = data_in[0];
	end
endmodule

/* verification/dacbuf_host_asserts.sv */
// Port checker for the converter host controller
`timescale 1ns/10ps
module dacbuf_host_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire logic clear_req_in,
	input wire logic req_ready_out,
	input wire logic done_out,
	input wire logic [15:0] data_out,
	input wire dacbuf_pkg::dacbuf_ctl_t ctl_out
);
	import dacbuf_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	latch_under_write_a: assert property (!ctl_out.input_latch_enable_n |-> !ctl_out.write_n)
		else $error("input latch enabled without write");
	dac_under_write_a: assert property (!ctl_out.dac_register_enable_n |-> !ctl_out.write_n)
		else $error("register enabled without write");
	xfer_select_a: assert property (!ctl_out.dac_transfer_enable_n |->
		!ctl_out.write_n && !ctl_out.select_n)
		else $error("transfer without write and select");
	serial_select_a: assert property (!ctl_out.low_byte_latch_n &&
		!ctl_out.high_byte_latch_n |-> !ctl_out.select_n)
		else $error("serial mode without select");
	strobe_data_a: assert property (!ctl_out.write_n && $past(!ctl_out.write_n) |->
		$stable(data_out))
		else $error("data moved during strobe");
	strobe_width_a: assert property ($fell(ctl_out.write_n) |-> (!ctl_out.write_n) [*5])
		else $error("write strobe too short");
	clear_issue_a: assert property (clear_req_in && req_ready_out |->
		##[1:3] !ctl_out.clear_n)
		else $error("clear not issued");
	take_ready_a: assert property ((req_valid_in || clear_req_in) && req_ready_out |=> !req_ready_out)
		else $error("ready held after take");
	done_pulse_a: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
endmodule
bind dacbuf_host dacbuf_host_asserts u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.req_valid_in(req_valid_in), .clear_req_in(clear_req_in), .req_ready_out(req_ready_out),
	.done_out(done_out), .data_out(data_out), .ctl_out(ctl_out));

/* verification/dacbuf_host_tb.sv */
// Self-checking bench for the converter host controller
`timescale 1ns/10ps
module dacbuf_host_tb;
	import dacbuf_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic req_valid_in = 1'b0;
	logic clear_req_in = 1'b0;
	dacbuf_req_t req_in = '0;
	logic req_ready_out, done_out;
	logic [15:0] data_out, word_dac, byte_latch, byte_dac;
	dacbuf_ctl_t ctl_out;
	int mismatches = 0;
	int compares = 0;
	always #10 clk_in = ~clk_in;
	dacbuf_host DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .clear_req_in(clear_req_in), .req_ready_out(req_ready_out),
		.done_out(done_out), .data_out(data_out), .ctl_out(ctl_out));
	dacbuf_dev_model u_dev (.data_in(data_out), .ctl_in(ctl_out), .word_dac_out(word_dac),
		.byte_latch_out(byte_latch), .byte_dac_out(byte_dac));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input logic clr, input logic [15:0] w, input logic [1:0] m, input logic u);
		int n;
		do @(negedge clk_in); while (req_ready_out !== 1'b1);
		@(posedge clk_in);
		req_in <= '{w, m, u};
		clear_req_in <= clr;
		req_valid_in <= !clr;
		@(posedge clk_in);
		clear_req_in <= 1'b0;
		req_valid_in <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (done_out !== 1'b1 && n < 2000);
		check({15'h0000, done_out}, 16'h0001);
	endtask
	task automatic t_reset;
		@(negedge clk_in);
		check({8'h00, ctl_out}, 16'h00ff);
		check(data_out, 16'h0000);
		check({14'h0000, req_ready_out, done_out}, 16'h0000);
	endtask
	task automatic t_word;
		run(1'b0, 16'ha5c3, DACBUF_MODE_WORD, 1'b0);
		check(word_dac, 16'ha5c3);
		run(1'b0, 16'h0001, DACBUF_MODE_WORD, 1'b1);
		check(word_dac, 16'h8001);
	endtask
	task automatic t_byte;
		run(1'b0, 16'h1234, DACBUF_MODE_BYTE, 1'b0);
		check(byte_dac, 16'h1234);
		run(1'b0, 16'hff00, DACBUF_MODE_BYTE, 1'b1);
		check(byte_dac, 16'h7f00);
	endtask
	task automatic t_serial;
		run(1'b0, 16'hc35a, DACBUF_MODE_SERIAL, 1'b0);
		check(byte_latch, 16'hc35a);
		check(byte_dac, 16'hc35a);
	endtask
	task automatic t_clear;
		run(1'b1, 16'h0000, DACBUF_MODE_WORD, 1'b0);
		check(byte_latch, 16'h0000);
		check(word_dac, 16'h0000);
		check(byte_dac, 16'h0000);
	endtask
	task automatic complete_run;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end
	initial begin
		t_reset();
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_word();
		t_byte();
		t_serial();
		t_clear();
		complete_run();
	end
endmodule
